// ---- logic/diag_cfg_pkg.sv ----
// Package for the input fault diagnostic configuration bank.
// Assumes an 8-bit register port in the device control logic.
`default_nettype none
package diag_cfg_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_SCAN_SELECT   = 8'h64;
    localparam logic [7:0] ADDR_THRESHOLD_A   = 8'h65;
    localparam logic [7:0] ADDR_THRESHOLD_B   = 8'h66;
    localparam logic [7:0] ADDR_TIMING_CFG    = 8'h67;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_SCAN_SELECT    = 8'h00;
    localparam logic [7:0] RST_THRESHOLD_A    = 8'h37;
    localparam logic [7:0] RST_THRESHOLD_B    = 8'h87;
    localparam logic [7:0] RST_TIMING_CFG     = 8'hb8;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CHAN_EN_HI     = 7;
    localparam int CHAN_EN_LO     = 4;
    localparam int SE_NEG_BIT     = 1;
    localparam int AC_COUP_BIT    = 0;
    localparam int NIB_HI_MSB     = 7;
    localparam int NIB_HI_LSB     = 4;
    localparam int NIB_LO_MSB     = 3;
    localparam int NIB_LO_LSB     = 0;
    localparam int REPEAT_MSB     = 7;
    localparam int REPEAT_LSB     = 6;
    localparam int DEBOUNCE_MSB   = 3;
    localparam int DEBOUNCE_LSB   = 2;
    localparam int BAT_DBNC_BIT   = 1;
    localparam int DOUBLE_BIT     = 0;

    // ------------------------------------------------------------
    // Threshold steps in millivolts
    // ------------------------------------------------------------
    localparam logic [6:0] STEP_30_MV = 7'h1e;
    localparam logic [6:0] STEP_60_MV = 7'h3c;

    // ------------------------------------------------------------
    // Repetition timing
    // ------------------------------------------------------------
    localparam int CLK_HZ         = 50_000_000;
    localparam int REP_1_MS       = 1;
    localparam int REP_4_MS       = 4;
    localparam int REP_8_MS       = 8;
    localparam int CYC_PER_MS     = CLK_HZ / 1000;

    // ------------------------------------------------------------
    // Debounce counts
    // ------------------------------------------------------------
    localparam logic [4:0] DBNC_16 = 5'h10;
    localparam logic [4:0] DBNC_8  = 5'h08;
    localparam logic [4:0] DBNC_4  = 5'h04;
    localparam logic [4:0] DBNC_0  = 5'h00;

    typedef enum logic [1:0] {
        REP_CONT  = 2'b00,
        REP_1MS   = 2'b01,
        REP_4MS   = 2'b10,
        REP_8MS   = 2'b11
    } repeat_sel_t;

    // Host register port request
    typedef struct packed {
        logic       wr_en;
        logic       rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // Decoded settings handed to the scanner
    typedef struct packed {
        logic [3:0]  chan_scan_on;
        logic        scan_single_ended_neg;
        logic        scan_ac_coupled_pins;
        logic [10:0] terminal_short_mv;
        logic [10:0] battery_short_mv;
        logic [10:0] ground_short_mv;
        logic [10:0] bias_short_mv;
        logic [4:0]  fault_debounce;
        logic [4:0]  battery_short_debounce;
    } diag_settings_t;

endpackage
`default_nettype wire

// ---- logic/diag_threshold_map.sv ----
// Maps one 4-bit threshold code to millivolts.
// Assumes clk with an asynchronous active-low rst_n; output is registered.
`timescale 1ns/10ps
`default_nettype none
module diag_threshold_map #(
    parameter logic [6:0] STEP_MV = diag_cfg_pkg::STEP_30_MV
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [3:0]  code,
    input  wire logic        double_on,
    output logic      [10:0] level_mv
);
    import diag_cfg_pkg::*;

    logic [10:0] next_level_mv;

    // Linear code times step, optionally doubled
    always_comb begin
        next_level_mv = 11'(code) * 11'(STEP_MV);
        if (double_on) begin
            next_level_mv = {next_level_mv[9:0], 1'b0};
        end
    end

    // Registered output
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level_mv <= 11'h000;
        end else begin
            level_mv <= next_level_mv;
        end
    end
endmodule
`default_nettype wire

// ---- logic/input_fault_diag_config.sv ----
// Configuration register bank for the input fault diagnostic scanner.
// Assumes host accesses arrive as a synchronous 8-bit register port.
`timescale 1ns/10ps
`default_nettype none
module input_fault_diag_config #(
    parameter int REP_8_CYCLES = diag_cfg_pkg::REP_8_MS * diag_cfg_pkg::CYC_PER_MS,
    parameter int REP_4_CYCLES = diag_cfg_pkg::REP_4_MS * diag_cfg_pkg::CYC_PER_MS,
    parameter int REP_1_CYCLES = diag_cfg_pkg::REP_1_MS * diag_cfg_pkg::CYC_PER_MS
) (
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    input  wire diag_cfg_pkg::reg_req_t       req,
    output logic                              rd_valid,
    output logic      [7:0]                   rd_data,
    output var  diag_cfg_pkg::diag_settings_t settings,
    output logic                              scan_start
);
    import diag_cfg_pkg::*;

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [7:0] diag_scan_select;
    logic [7:0] short_threshold_a;
    logic [7:0] short_threshold_b;
    logic [7:0] diag_timing_cfg;

    logic       threshold_double;
    logic [1:0] scan_repeat_sel;
    logic [1:0] fault_debounce_sel;
    logic       battery_short_debounce;

    assign threshold_double       = diag_timing_cfg[DOUBLE_BIT];
    assign scan_repeat_sel        = diag_timing_cfg[REPEAT_MSB:REPEAT_LSB];
    assign fault_debounce_sel     = diag_timing_cfg[DEBOUNCE_MSB:DEBOUNCE_LSB];
    assign battery_short_debounce = diag_timing_cfg[BAT_DBNC_BIT];

    // Host writes; reserved bits stored as written
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            diag_scan_select  <= RST_SCAN_SELECT;
            short_threshold_a <= RST_THRESHOLD_A;
            short_threshold_b <= RST_THRESHOLD_B;
            diag_timing_cfg   <= RST_TIMING_CFG;
        end else if (req.wr_en) begin
            case (req.addr)
                ADDR_SCAN_SELECT: begin
                    diag_scan_select <= req.wdata;
                end
                ADDR_THRESHOLD_A: begin
                    short_threshold_a <= req.wdata;
                end
                ADDR_THRESHOLD_B: begin
                    short_threshold_b <= req.wdata;
                end
                ADDR_TIMING_CFG: begin
                    diag_timing_cfg <= req.wdata;
                end
                default: begin
                end
            endcase
        end
    end

    // Read-back, unmapped reads return zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_valid <= 1'b0;
            rd_data  <= 8'h00;
        end else begin
            rd_valid <= req.rd_en;
            if (req.rd_en) begin
                case (req.addr)
                    ADDR_SCAN_SELECT: rd_data <= diag_scan_select;
                    ADDR_THRESHOLD_A: rd_data <= short_threshold_a;
                    ADDR_THRESHOLD_B: rd_data <= short_threshold_b;
                    ADDR_TIMING_CFG:  rd_data <= diag_timing_cfg;
                    default:          rd_data <= 8'h00;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Scan selection
    // ------------------------------------------------------------
    logic [3:0] chan_scan_on;
    logic [3:0] held_chan_scan;
    logic       held_se_neg;
    logic       held_ac_pins;

    // Bit 7 is channel 1 down to bit 4 channel 4
    genvar ch;
    generate
        for (ch = 0; ch < 4; ch++) begin : g_chan
            assign chan_scan_on[ch] = diag_scan_select[CHAN_EN_HI - ch];
        end
    endgenerate

    // Hold scan selection flags for the scanner
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            held_chan_scan <= 4'h0;
            held_se_neg    <= 1'b0;
            held_ac_pins   <= 1'b0;
        end else begin
            held_chan_scan <= chan_scan_on;
            held_se_neg    <= diag_scan_select[SE_NEG_BIT];
            held_ac_pins   <= diag_scan_select[AC_COUP_BIT];
        end
    end

    // ------------------------------------------------------------
    // Thresholds in millivolts
    // ------------------------------------------------------------
    logic [10:0] term_level_mv;
    logic [10:0] bat_level_mv;
    logic [10:0] gnd_level_mv;
    logic [10:0] bias_level_mv;

    // One registered mapper per threshold field
    diag_threshold_map #(.STEP_MV(STEP_30_MV)) u_term (
        .clk       (clk),
        .rst_n     (rst_n),
        .code      (short_threshold_a[NIB_HI_MSB:NIB_HI_LSB]),
        .double_on (threshold_double),
        .level_mv  (term_level_mv)
    );
    diag_threshold_map #(.STEP_MV(STEP_30_MV)) u_bat (
        .clk       (clk),
        .rst_n     (rst_n),
        .code      (short_threshold_a[NIB_LO_MSB:NIB_LO_LSB]),
        .double_on (threshold_double),
        .level_mv  (bat_level_mv)
    );
    diag_threshold_map #(.STEP_MV(STEP_60_MV)) u_gnd (
        .clk       (clk),
        .rst_n     (rst_n),
        .code      (short_threshold_b[NIB_HI_MSB:NIB_HI_LSB]),
        .double_on (threshold_double),
        .level_mv  (gnd_level_mv)
    );
    diag_threshold_map #(.STEP_MV(STEP_30_MV)) u_bias (
        .clk       (clk),
        .rst_n     (rst_n),
        .code      (short_threshold_b[NIB_LO_MSB:NIB_LO_LSB]),
        .double_on (threshold_double),
        .level_mv  (bias_level_mv)
    );

    // ------------------------------------------------------------
    // Debounce counts
    // ------------------------------------------------------------
    logic [4:0] held_fault_dbnc;
    logic [4:0] held_bat_dbnc;

    // Decode debounce selections; reset matches the timing reset value
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            held_fault_dbnc <= DBNC_4;
            held_bat_dbnc   <= DBNC_16;
        end else begin
            case (fault_debounce_sel)
                2'h0:    held_fault_dbnc <= DBNC_16;
                2'h1:    held_fault_dbnc <= DBNC_8;
                2'h2:    held_fault_dbnc <= DBNC_4;
                default: held_fault_dbnc <= DBNC_0;
            endcase
            held_bat_dbnc <= battery_short_debounce ? DBNC_8 : DBNC_16;
        end
    end

    // ------------------------------------------------------------
    // Scan repetition timer
    // ------------------------------------------------------------
    logic [31:0] rep_count;
    logic [31:0] rep_limit;

    always_comb begin
        case (repeat_sel_t'(scan_repeat_sel))
            REP_1MS: rep_limit = 32'(REP_1_CYCLES);
            REP_4MS: rep_limit = 32'(REP_4_CYCLES);
            REP_8MS: rep_limit = 32'(REP_8_CYCLES);
            default: rep_limit = 32'h0000_0001;
        endcase
    end

    // Continuous mode pulses every cycle; otherwise one pulse per period
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rep_count  <= 32'h0000_0000;
            scan_start <= 1'b0;
        end else if (rep_count + 32'h0000_0001 >= rep_limit) begin
            rep_count  <= 32'h0000_0000;
            scan_start <= 1'b1;
        end else begin
            rep_count  <= rep_count + 32'h0000_0001;
            scan_start <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Settings bundle
    // ------------------------------------------------------------
    // Pure wiring of flops, so each field keeps a single driver
    assign settings = '{
        chan_scan_on:           held_chan_scan,
        scan_single_ended_neg:  held_se_neg,
        scan_ac_coupled_pins:   held_ac_pins,
        terminal_short_mv:      term_level_mv,
        battery_short_mv:       bat_level_mv,
        ground_short_mv:        gnd_level_mv,
        bias_short_mv:          bias_level_mv,
        fault_debounce:         held_fault_dbnc,
        battery_short_debounce: held_bat_dbnc
    };
endmodule
`default_nettype wire

// ---- tb/diag_host_model.sv ----
// Host model driving the configuration bank register port.
// Assumes the bank answers reads one cycle after the strobe.
`timescale 1ns/10ps
`default_nettype none
module diag_host_model (
    input  wire logic                   clk,
    output var  diag_cfg_pkg::reg_req_t req,
    input  wire logic                   rd_valid,
    input  wire logic [7:0]             rd_data
);
    import diag_cfg_pkg::*;

    initial req = '0;

    // One write strobe; reserved scan bits always written as zero
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        req.addr = a;
        req.wdata = (a == ADDR_SCAN_SELECT) ? (d & 8'hf3) : d;
        req.wr_en = 1'b1;
        @(negedge clk);
        req.wr_en = 1'b0;
        req.wdata = ~req.wdata; // Released bus shows no stale value
    endtask

    // One read strobe; answer taken a cycle later
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(negedge clk);
        req.addr = a;
        req.rd_en = 1'b1;
        @(negedge clk);
        req.rd_en = 1'b0;
        req.addr = ~a;
        ok = rd_valid;
        d = rd_data;
    endtask
endmodule
`default_nettype wire

// ---- tb/input_fault_diag_config_chk.sv ----
// Port checker for the diagnostic configuration bank.
// Assumes it is bound into the bank top with its parameters.
`timescale 1ns/10ps
`default_nettype none
module input_fault_diag_config_chk #(
    parameter int REP_8_CYCLES = 80,
    parameter int REP_4_CYCLES = 40,
    parameter int REP_1_CYCLES = 10
) (
    input wire logic                         clk,
    input wire logic                         rst_n,
    input wire diag_cfg_pkg::reg_req_t       req,
    input wire logic                         rd_valid,
    input wire logic [7:0]                   rd_data,
    input wire diag_cfg_pkg::diag_settings_t settings,
    input wire logic                         scan_start
);
    import diag_cfg_pkg::*;
    logic [7:0]     sh [4];
    diag_settings_t exp_set;
    logic [7:0]     rd_exp;
    int             idle_cycles;

    // Cycles since the last scan start
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idle_cycles <= 0;
        end else if (scan_start) begin
            idle_cycles <= 0;
        end else begin
            idle_cycles <= idle_cycles + 1;
        end
    end

    // Shadow of the four registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sh <= '{RST_SCAN_SELECT, RST_THRESHOLD_A, RST_THRESHOLD_B, RST_TIMING_CFG};
        end else if (req.wr_en && req.addr[7:2] == 6'h19) begin
            sh[req.addr[1:0]] <= req.wdata;
        end
    end

    // Expected settings and read data from the shadow
    always_comb begin
        exp_set.chan_scan_on = {sh[0][4], sh[0][5], sh[0][6], sh[0][7]};
        exp_set.scan_single_ended_neg = sh[0][1];
        exp_set.scan_ac_coupled_pins = sh[0][0];
        exp_set.terminal_short_mv = (11'(sh[1][7:4]) * 11'(STEP_30_MV)) << sh[3][0];
        exp_set.battery_short_mv = (11'(sh[1][3:0]) * 11'(STEP_30_MV)) << sh[3][0];
        exp_set.ground_short_mv = (11'(sh[2][7:4]) * 11'(STEP_60_MV)) << sh[3][0];
        exp_set.bias_short_mv = (11'(sh[2][3:0]) * 11'(STEP_30_MV)) << sh[3][0];
        exp_set.fault_debounce = (sh[3][3:2] == 2'h3) ? DBNC_0 : (DBNC_16 >> sh[3][3:2]);
        exp_set.battery_short_debounce = sh[3][1] ? DBNC_8 : DBNC_16;
        rd_exp = (req.addr[7:2] == 6'h19) ? sh[req.addr[1:0]] : 8'h00;
    end

    a_read_valid: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> rd_valid == $past(req.rd_en)) else $error("read valid misplaced");
    a_read_data: assert property (@(posedge clk) disable iff (!rst_n)
        req.rd_en |=> rd_data == $past(rd_exp)) else $error("read data wrong");
    a_chan_enable: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rst_n) |-> settings.chan_scan_on == $past(exp_set.chan_scan_on)) else $error("channel enables wrong");
    a_pin_include: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rst_n) |-> {settings.scan_single_ended_neg, settings.scan_ac_coupled_pins}
        == $past({exp_set.scan_single_ended_neg, exp_set.scan_ac_coupled_pins})) else $error("pin include wrong");
    a_thresh_a: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rst_n) |-> {settings.terminal_short_mv, settings.battery_short_mv}
        == $past({exp_set.terminal_short_mv, exp_set.battery_short_mv})) else $error("threshold A wrong");
    a_thresh_b: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rst_n) |-> {settings.ground_short_mv, settings.bias_short_mv}
        == $past({exp_set.ground_short_mv, exp_set.bias_short_mv})) else $error("threshold B wrong");
    a_debounce_sel: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rst_n) |-> {settings.fault_debounce, settings.battery_short_debounce}
        == $past({exp_set.fault_debounce, exp_set.battery_short_debounce})) else $error("debounce wrong");
    a_repeat_cont: assert property (@(posedge clk) disable iff (!rst_n)
        scan_start && sh[3][7:6] == 2'h0 ##1 sh[3][7:6] == 2'h0 |-> scan_start) else $error("scan gap in continuous");
    a_repeat_bound: assert property (@(posedge clk) disable iff (!rst_n)
        idle_cycles < REP_8_CYCLES) else $error("scan start overdue");
endmodule
bind input_fault_diag_config input_fault_diag_config_chk #(
    .REP_8_CYCLES(REP_8_CYCLES),
    .REP_4_CYCLES(REP_4_CYCLES),
    .REP_1_CYCLES(REP_1_CYCLES)
) chk (.clk(clk), .rst_n(rst_n), .req(req), .rd_valid(rd_valid), .rd_data(rd_data),
    .settings(settings), .scan_start(scan_start));
`default_nettype wire

// ---- tb/test_input_fault_diag_config.sv ----
// Self-checking bench for the diagnostic configuration bank.
// Assumes short repetition parameters of 10, 40 and 80 cycles.
`timescale 1ns/10ps
`default_nettype none
module test_input_fault_diag_config;
    import diag_cfg_pkg::*;
    localparam int R1 = 10;
    localparam int R4 = 40;
    localparam int R8 = 80;
    logic           clk = 1'b0;
    logic           rst_n = 1'b0;
    reg_req_t       req;
    logic           rd_valid;
    logic [7:0]     rd_data;
    diag_settings_t settings;
    logic           scan_start;
    int             errors = 0;
    int             check_count = 0;
    int             n;
    logic [10:0]    gaps [4] = '{11'h001, 11'(R1), 11'(R4), 11'(R8)};

    always #10 clk = ~clk;

    input_fault_diag_config #(.REP_8_CYCLES(R8), .REP_4_CYCLES(R4), .REP_1_CYCLES(R1)) u_input_fault_diag_config (
        .clk(clk), .rst_n(rst_n), .req(req), .rd_valid(rd_valid), .rd_data(rd_data),
        .settings(settings), .scan_start(scan_start));
    diag_host_model host (.clk(clk), .req(req), .rd_valid(rd_valid), .rd_data(rd_data));

    task automatic test_done();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk_set(input logic [10:0] got, input logic [10:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       ok;
        host.rd(a, d, ok);
        chk_set({10'h0, ok}, 11'h001);
        chk_set({3'h0, d}, {3'h0, exp});
    endtask

    // Cycles from one scan start to the next, bounded
    task automatic wait_pulse(output int cnt);
        cnt = 0;
        do begin
            @(negedge clk);
            cnt++;
            if (cnt > 300) begin
                errors++;
                test_done();
            end
        end while (scan_start !== 1'b1);
    endtask

    initial begin
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        chk_reg(ADDR_SCAN_SELECT, 8'h00);
        chk_reg(ADDR_THRESHOLD_A, 8'h37);
        chk_reg(ADDR_THRESHOLD_B, 8'h87);
        chk_reg(ADDR_TIMING_CFG, 8'hb8);
        chk_reg(8'h63, 8'h00);
        chk_reg(8'h68, 8'h00);
        chk_set(settings.terminal_short_mv, 11'h05a);
        chk_set(settings.battery_short_mv, 11'h0d2);
        chk_set(settings.ground_short_mv, 11'h1e0);
        chk_set(settings.bias_short_mv, 11'h0d2);
        chk_set({6'h0, settings.fault_debounce}, 11'h004);
        $display("test reset values done");
        host.wr(ADDR_SCAN_SELECT, 8'hff);
        chk_reg(ADDR_SCAN_SELECT, 8'hf3);
        chk_set({7'h0, settings.chan_scan_on}, 11'h00f);
        host.wr(ADDR_SCAN_SELECT, 8'h81);
        @(negedge clk);
        chk_set({7'h0, settings.chan_scan_on}, 11'h001);
        chk_set({9'h0, settings.scan_single_ended_neg, settings.scan_ac_coupled_pins}, 11'h001);
        host.wr(ADDR_THRESHOLD_A, 8'hf0);
        host.wr(ADDR_THRESHOLD_B, 8'hf1);
        @(negedge clk);
        chk_set(settings.terminal_short_mv, 11'h1c2);
        chk_set(settings.battery_short_mv, 11'h000);
        chk_set(settings.ground_short_mv, 11'h384);
        chk_set(settings.bias_short_mv, 11'h01e);
        host.wr(ADDR_TIMING_CFG, 8'h3f);
        @(negedge clk);
        chk_set(settings.terminal_short_mv, 11'h384);
        chk_set(settings.ground_short_mv, 11'h708);
        chk_set(settings.bias_short_mv, 11'h03c);
        chk_set({1'h0, settings.fault_debounce, settings.battery_short_debounce}, 11'h008);
        for (int k = 0; k < 3; k++) begin
            host.wr(ADDR_TIMING_CFG, {4'hb, 2'(k), 2'h0});
            @(negedge clk);
            chk_set({6'h0, settings.fault_debounce}, 11'h010 >> k);
            chk_set({6'h0, settings.battery_short_debounce}, 11'h010);
        end
        $display("test fields done");
        for (int r = 0; r < 4; r++) begin
            host.wr(ADDR_TIMING_CFG, {2'(r), 6'h38});
            repeat (3) wait_pulse(n);
            chk_set(11'(n), gaps[r]);
        end
        $display("test repetition done");
        rst_n = 1'b0;
        @(negedge clk);
        rst_n = 1'b1;
        chk_reg(ADDR_THRESHOLD_A, 8'h37);
        chk_reg(ADDR_SCAN_SELECT, 8'h00);
        $display("test second reset done");
        test_done();
    end
endmodule
`default_nettype wire
